// [cpu_bus_pkg.sv]
// Purpose: shared types and constants for the cpu bus cycle sequencer
// Assumes: one clock, bus states advance on the selected state tick
// Notes:   big-endian byte lanes, even address on data[15:8]
package cpu_bus_pkg;

    localparam int          EA_W           = 24;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          BYTE_W         = 8;
    localparam int          PORT_W         = 8;
    localparam logic [1:0]  FAST_STATES    = 2'h2;
    localparam logic [1:0]  SLOW_STATES    = 2'h3;
    localparam logic [1:0]  FIRST_STATE    = 2'h1;
    localparam logic [7:0]  WO_READ_VALUE  = 8'hFF;
    localparam logic [7:0]  COUNT_ZERO     = 8'h00;
    localparam logic [7:0]  COUNT_LAST     = 8'h01;
    localparam logic [15:0] ADDR_STEP      = 16'h0001;

    typedef enum logic [1:0] {
        CPU_RESET  = 2'b00,
        CPU_EXCEPT = 2'b01,
        CPU_EXEC   = 2'b11,
        CPU_HALT   = 2'b10
    } cpu_state_t;

    typedef enum logic [1:0] {
        HALT_SLEEP    = 2'b00,
        HALT_STANDBY  = 2'b01,
        HALT_SUBSLEEP = 2'b11
    } halt_mode_t;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_LOOK = 3'b001,
        BS_T1   = 3'b011,
        BS_T2   = 3'b010,
        BS_T3   = 3'b110
    } bus_state_t;

    typedef enum logic [2:0] {
        OP_READ          = 3'h0,
        OP_WRITE         = 3'h1,
        OP_SET_BIT       = 3'h2,
        OP_CLEAR_BIT     = 3'h3,
        OP_INVERT_BIT    = 3'h4,
        OP_STORE_BIT     = 3'h5,
        OP_STORE_INV_BIT = 3'h6,
        OP_BLOCK_COPY    = 3'h7
    } op_t;

    typedef struct packed {
        op_t               op;
        logic              word;
        logic [EA_W-1:0]   addr;
        logic [DATA_W-1:0] wdata;
        logic [2:0]        bit_sel;
        logic              bit_val;
        logic [7:0]        copy_count_byte;
        logic [ADDR_W-1:0] copy_source_pointer;
        logic [ADDR_W-1:0] copy_dest_pointer;
    } req_t;

    typedef struct packed {
        logic is_mem;
        logic three_state;
        logic wide16;
        logic write_only;
        logic is_port;
        logic is_empty;
    } attr_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              rd;
        logic              wr;
        logic              word;
    } bus_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic              done;
        logic              err;
    } resp_t;

endpackage

// [port_pin_readback.sv]
// Purpose: port readback value, pin level for inputs, latch for outputs
// Assumes: pins are asynchronous to i_clk
// Notes:   a pin change counts once the second and third stages agree
module port_pin_readback #(
    parameter int W = 8
) (
    input  logic         i_clk,
    input  logic         i_reset_n,
    input  logic         i_clk_en,
    input  logic [W-1:0] i_pins,
    input  logic [W-1:0] i_dir,
    input  logic [W-1:0] i_latch,
    output logic [W-1:0] o_value
);

    logic [W-1:0] sync1_ff;
    logic [W-1:0] sync2_ff;
    logic [W-1:0] sync3_ff;
    logic [W-1:0] stable_ff;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            sync3_ff  <= '0;
            stable_ff <= '0;
        end else if (i_clk_en) begin
            sync1_ff <= i_pins;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int i = 0; i < W; i++) begin
                if (sync2_ff[i] == sync3_ff[i]) begin
                    stable_ff[i] <= sync3_ff[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_value <= '0;
        end else if (i_clk_en) begin
            o_value <= (i_dir & i_latch) | (~i_dir & stable_ff); // RL16
        end
    end

endmodule

// [cpu_bus_cycle_rmw.sv]
// Purpose: cpu internal bus cycle sequencer with bit read-modify-write
// Assumes: i_attr decodes o_bus.addr combinationally in the same cycle
// Notes:   one bus state per tick of the clock that drives the cpu

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: every bus cycle lasts two or three states, chosen by target
// RL2: a state is one tick of the main clock or subclock in use
// RL3: memory cycles take two states, 16-bit path, byte or word
// RL4: peripheral cycles take two or three states, 8- or 16-bit path
// RL5: 16-bit peripheral registers take word access only
// RL6: word access to 8-bit register becomes two byte cycles
// RL7: two-state peripheral cycles time exactly like memory cycles
// RL8: cpu is in reset, execution, halt or exception handling
// RL9: execution splits into active and subactive mode
// RL10: halt splits into sleep, standby and sub-sleep
// RL11: writes to empty space are dropped, reads undefined
// RL12: block copy moves count bytes from source to destination
// RL13: software keeps copy destination from wrapping past top
// RL14: bit instructions read a byte, change one bit, write back
// RL15: shared counter/reload address: read counter, write reload
// RL16: port reads give pin level on inputs, latch on outputs
// RL17: software should modify a shadow copy, then write the port
// RL18: write-only registers read as all ones
// RL19: only low 16 bits of the 24-bit address are used
// RL20: split word access does even byte first, then odd
module cpu_bus_cycle_rmw (
    input  logic                           i_clk,
    input  logic                           i_reset_n,
    input  logic                           i_clk_en,
    input  logic                           i_main_tick,
    input  logic                           i_sub_tick,
    input  logic                           i_req_valid,
    input  cpu_bus_pkg::req_t              i_req,
    output logic                           o_busy,
    output cpu_bus_pkg::resp_t             o_resp,
    output cpu_bus_pkg::bus_t              o_bus,
    input  cpu_bus_pkg::attr_t             i_attr,
    input  logic [cpu_bus_pkg::DATA_W-1:0] i_rdata,
    input  logic [cpu_bus_pkg::PORT_W-1:0] i_port5_pins,
    input  logic [cpu_bus_pkg::PORT_W-1:0] i_port5_direction_control,
    input  logic [cpu_bus_pkg::PORT_W-1:0] i_port5_output_latch,
    input  logic                           i_exc_req,
    input  logic                           i_exc_done,
    input  logic                           i_halt_req,
    input  cpu_bus_pkg::halt_mode_t        i_halt_mode,
    input  logic                           i_wake,
    input  logic                           i_sub_sel,
    output cpu_bus_pkg::cpu_state_t        o_cpu_state,
    output logic                           o_sub_active,
    output cpu_bus_pkg::halt_mode_t        o_halt_mode
);
    import cpu_bus_pkg::*;

    bus_state_t       bs_ff;
    req_t             req_ff;
    attr_t            attr_ff;
    logic             split_ff, half_ff, wr_phase_ff;
    logic [7:0]       hi_ff, cnt_ff;
    logic [15:0]      src_ff, dst_ff;
    logic [1:0]       st_cnt_ff;
    logic [7:0]       port_value, lane_byte, rd_byte, bit_mask;
    logic             tick, three_cyc, cyc_end, word_req, bit_op, accept_ok;

    function automatic logic [7:0] bit_modify(op_t op, logic [7:0] d, logic [2:0] n, logic v);
        logic [7:0] m;
        m = 8'h01 << n;
        case (op)
            OP_SET_BIT:       return d | m;
            OP_CLEAR_BIT:     return d & ~m;
            OP_INVERT_BIT:    return d ^ m;
            OP_STORE_BIT:     return v ? (d | m) : (d & ~m);
            OP_STORE_INV_BIT: return v ? (d & ~m) : (d | m);
            default:          return d;
        endcase
    endfunction

    port_pin_readback #(.W(PORT_W)) u_port5 (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_pins    (i_port5_pins),
        .i_dir     (i_port5_direction_control),
        .i_latch   (i_port5_output_latch),
        .o_value   (port_value)
    );

    // state tick follows whichever clock drives the cpu
    assign tick      = i_clk_en & (o_sub_active ? i_sub_tick : i_main_tick); // RL2
    assign three_cyc = attr_ff.three_state & ~attr_ff.is_mem;              // RL3 RL7
    assign cyc_end   = tick & ((bs_ff == BS_T2 & ~three_cyc) | (bs_ff == BS_T3)); // RL1
    assign word_req  = req_ff.word & (req_ff.op == OP_READ | req_ff.op == OP_WRITE);
    assign bit_op    = req_ff.op inside {[OP_SET_BIT:OP_STORE_INV_BIT]};
    assign accept_ok = (o_cpu_state == CPU_EXEC & ~i_halt_req & ~i_exc_req)
                     | (o_cpu_state == CPU_EXCEPT);
    assign lane_byte = o_bus.addr[0] ? i_rdata[7:0] : i_rdata[15:8];
    assign rd_byte   = attr_ff.is_port    ? port_value    :           // RL16
                       attr_ff.write_only ? WO_READ_VALUE : lane_byte; // RL18
    assign bit_mask  = 8'h01 << req_ff.bit_sel;

    ////////////////////////////////////////////////////////////////////////////
    // cpu top-level state
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cpu_state  <= CPU_RESET;
            o_sub_active <= 1'b0;
            o_halt_mode  <= HALT_SLEEP;
        end else if (i_clk_en) begin
            case (o_cpu_state) // RL8
                CPU_RESET:  o_cpu_state <= CPU_EXCEPT; // reset exception after release
                CPU_EXCEPT: if (i_exc_done & ~o_busy) o_cpu_state <= CPU_EXEC;
                CPU_EXEC: begin
                    if (!o_busy) begin
                        o_sub_active <= i_sub_sel; // RL9
                        if (i_exc_req) begin
                            o_cpu_state <= CPU_EXCEPT;
                        end else if (i_halt_req) begin
                            o_cpu_state <= CPU_HALT;
                            o_halt_mode <= i_halt_mode; // RL10
                        end
                    end
                end
                CPU_HALT: begin
                    if (i_exc_req) o_cpu_state <= CPU_EXCEPT;
                    else if (i_wake) o_cpu_state <= CPU_EXEC;
                end
                default: o_cpu_state <= CPU_RESET;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // bus cycle sequencer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bs_ff   <= BS_IDLE;
            req_ff  <= '0;
            attr_ff <= '0;
            o_bus   <= '0;
            o_resp  <= '0;
            {o_busy, split_ff, half_ff, wr_phase_ff} <= '0;
            {hi_ff, cnt_ff, src_ff, dst_ff}          <= '0;
        end else if (i_clk_en) begin
            o_resp.done <= 1'b0;
            o_resp.err  <= 1'b0;
            case (bs_ff)
                BS_IDLE: begin
                    if (tick & i_req_valid & accept_ok) begin
                        req_ff      <= i_req;
                        o_busy      <= 1'b1;
                        half_ff     <= 1'b0;
                        wr_phase_ff <= (i_req.op == OP_WRITE);
                        cnt_ff      <= i_req.copy_count_byte; // RL12
                        src_ff      <= i_req.copy_source_pointer;
                        dst_ff      <= i_req.copy_dest_pointer;
                        o_bus.addr  <= (i_req.op == OP_BLOCK_COPY) ?
                                       i_req.copy_source_pointer : i_req.addr[15:0]; // RL19
                        o_bus.wdata <= i_req.word ? i_req.wdata : {2{i_req.wdata[7:0]}};
                        if (i_req.op == OP_BLOCK_COPY && i_req.copy_count_byte == COUNT_ZERO) begin
                            o_busy      <= 1'b0; // nothing to move
                            o_resp.done <= 1'b1;
                        end else begin
                            bs_ff <= BS_LOOK;
                        end
                    end
                end
                BS_LOOK: begin
                    if (tick) begin
                        attr_ff <= i_attr;
                        if (!word_req && i_attr.wide16 && !i_attr.is_mem) begin
                            bs_ff        <= BS_IDLE; // RL5
                            o_busy       <= 1'b0;
                            o_resp.done  <= 1'b1;
                            o_resp.err   <= 1'b1;
                        end else begin
                            bs_ff      <= BS_T1;
                            o_bus.word <= word_req & (i_attr.is_mem | i_attr.wide16); // RL3 RL4
                            split_ff   <= word_req & ~i_attr.is_mem & ~i_attr.wide16; // RL6
                            o_bus.rd   <= ~wr_phase_ff;
                            o_bus.wr   <= wr_phase_ff & ~i_attr.is_empty; // RL11
                            if (word_req && !i_attr.is_mem && !i_attr.wide16) begin
                                o_bus.addr[0] <= 1'b0; // RL20
                                o_bus.wdata   <= {2{req_ff.wdata[15:8]}};
                            end
                        end
                    end
                end
                BS_T1:   if (tick) bs_ff <= BS_T2;
                BS_T2:   if (tick && three_cyc) bs_ff <= BS_T3; // RL4
                BS_T3:   bs_ff <= BS_T3; // held until the ending tick
                default: bs_ff <= BS_IDLE;
            endcase
            if (cyc_end) begin
                o_bus.rd <= 1'b0;
                o_bus.wr <= 1'b0;
                bs_ff    <= BS_IDLE;
                if (req_ff.op == OP_READ || req_ff.op == OP_WRITE) begin
                    if (split_ff && !half_ff) begin
                        half_ff       <= 1'b1; // RL6 RL20
                        hi_ff         <= rd_byte;
                        o_bus.addr[0] <= 1'b1;
                        o_bus.wdata   <= {2{req_ff.wdata[7:0]}};
                        o_bus.rd      <= o_bus.rd;
                        o_bus.wr      <= o_bus.wr;
                        bs_ff         <= BS_T1;
                    end else begin
                        o_busy       <= 1'b0;
                        o_resp.done  <= 1'b1;
                        o_resp.rdata <= o_bus.word ? i_rdata :
                                        split_ff   ? {hi_ff, rd_byte} : {8'h00, rd_byte};
                    end
                end else if (bit_op) begin
                    if (!wr_phase_ff) begin
                        // write back to the same address; a shared pair lands in reload
                        wr_phase_ff   <= 1'b1; // RL14 RL15
                        o_resp.rdata  <= {8'h00, rd_byte};
                        o_bus.wdata   <= {2{bit_modify(req_ff.op, rd_byte, req_ff.bit_sel,
                                                       req_ff.bit_val)}};
                        o_bus.wr      <= ~attr_ff.is_empty; // RL11
                        bs_ff         <= BS_T1;
                    end else begin
                        o_busy      <= 1'b0;
                        o_resp.done <= 1'b1;
                    end
                end else begin
                    // no wrap guard on the destination: software keeps it in range
                    if (!wr_phase_ff) begin
                        wr_phase_ff <= 1'b1; // RL12
                        o_bus.addr  <= dst_ff;
                        o_bus.wdata <= {2{rd_byte}};
                        bs_ff       <= BS_LOOK;
                    end else if (cnt_ff == COUNT_LAST) begin
                        o_busy      <= 1'b0;
                        o_resp.done <= 1'b1;
                    end else begin
                        wr_phase_ff <= 1'b0;
                        cnt_ff      <= cnt_ff - COUNT_LAST;
                        src_ff      <= src_ff + ADDR_STEP;
                        dst_ff      <= dst_ff + ADDR_STEP; // RL13
                        o_bus.addr  <= src_ff + ADDR_STEP;
                        bs_ff       <= BS_LOOK;
                    end
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // state count of the running cycle, read only by checks
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_cnt_ff <= FIRST_STATE;
        end else if (i_clk_en) begin
            if (cyc_end || bs_ff == BS_IDLE || bs_ff == BS_LOOK) begin
                st_cnt_ff <= FIRST_STATE;
            end else if (tick && (bs_ff == BS_T1 || bs_ff == BS_T2)) begin
                st_cnt_ff <= st_cnt_ff + FIRST_STATE;
            end
        end
    end

    AST_CYCLE_LEN: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL1
        cyc_end |-> st_cnt_ff == (three_cyc ? SLOW_STATES : FAST_STATES))
        else $error("bus cycle length wrong");
    AST_MEM_TWO_STATES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL3
        (bs_ff == BS_T3) |-> !attr_ff.is_mem)
        else $error("memory cycle took three states");
    AST_FAST_LIKE_MEM: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL7
        (bs_ff == BS_T2 && tick && !attr_ff.three_state) |=> bs_ff != BS_T3)
        else $error("two-state peripheral cycle stretched");
    AST_WIDE_WORD_ONLY: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL5
        ((o_bus.rd || o_bus.wr) && attr_ff.wide16 && !attr_ff.is_mem) |-> o_bus.word)
        else $error("byte access to wide register");
    AST_SPLIT_ODD_SECOND: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL20
        $rose(half_ff) |-> o_bus.addr[0] && $past(o_bus.addr[0]) == 1'b0)
        else $error("split word order wrong");
    AST_RMW_SAME_ADDR: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL14
        (o_bus.wr && bit_op) |-> o_bus.addr == req_ff.addr[15:0] && !o_bus.word)
        else $error("bit write went elsewhere");
    AST_WO_ALL_ONES: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL18
        (o_bus.wr && bit_op && attr_ff.write_only)
        |-> (o_bus.wdata[7:0] | bit_mask) == WO_READ_VALUE)
        else $error("write-only readback not all ones");
    AST_EMPTY_NO_WRITE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL11
        o_bus.wr |-> !attr_ff.is_empty)
        else $error("write strobed into empty space");
    AST_STATE_ON_TICK: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL2
        (bs_ff == BS_T1 && !tick) |=> bs_ff == BS_T1)
        else $error("bus state moved without a tick");
    AST_HALT_IDLE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RL10
        (o_cpu_state == CPU_HALT) |-> !o_busy && !o_bus.rd && !o_bus.wr)
        else $error("bus active in halt");

endmodule

// [periph_model.sv]
// Purpose: memory and register model behind the cpu bus
// Assumes: F0xx 8-bit 3-state, F1xx 8-bit, F2xx 16-bit 3-state, F3xx write-only, F4xx port
// Notes:   Exxx is empty; reads there return a pattern changing every cycle
module periph_model (
    input  logic                           i_clk,
    input  cpu_bus_pkg::bus_t              i_bus,
    output cpu_bus_pkg::attr_t             o_attr,
    output logic [cpu_bus_pkg::DATA_W-1:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_bus_pkg::*;
    logic [7:0]  mem [65536] = '{default: 8'h00};
    logic [15:0] junk = 16'h5a5a;
    logic [15:0] a;
    logic        p;
    assign a = i_bus.addr;
    assign p = a[15:12] == 4'hF;
    assign o_attr = '{a[15:12] < 4'hE, p && a[11:8] inside {4'h0, 4'h2},
                      p && a[11:8] == 4'h2, p && a[11:8] == 4'h3,
                      p && a[11:8] == 4'h4, a[15:12] == 4'hE};
    // junk off the read strobe so a late sample cannot pass
    assign o_rdata = (i_bus.rd && !o_attr.is_empty) ?
                     {mem[{a[15:1], 1'b0}], mem[{a[15:1], 1'b1}]} : junk;
    always @(posedge i_clk) begin
        junk <= {junk[14:0], ~junk[15]};
        if (i_bus.wr && i_bus.word) begin
            mem[{a[15:1], 1'b0}] <= i_bus.wdata[15:8];
            mem[{a[15:1], 1'b1}] <= i_bus.wdata[7:0];
        end else if (i_bus.wr) begin
            mem[a] <= a[0] ? i_bus.wdata[7:0] : i_bus.wdata[15:8];
        end
    end
endmodule

// [cpu_bus_cycle_rmw_test.sv]
// Purpose: self-checking bench for the cpu bus cycle sequencer
// Assumes: periph_model map; main tick every cycle except during the subactive read, sub tick random
// Notes:   reference memory mirrors every write that reaches the bus
module cpu_bus_cycle_rmw_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cpu_bus_pkg::*;
    logic i_clk = 0, i_reset_n = 0, i_clk_en = 1, i_main_tick = 1, i_sub_tick = 0;
    logic i_req_valid = 0, i_exc_req = 0, i_exc_done = 0, i_halt_req = 0, i_wake = 0;
    logic i_sub_sel = 0, o_busy, o_sub_active;
    logic [7:0] i_port5_pins = 0, i_port5_direction_control = 0, i_port5_output_latch = 0;
    logic [15:0] i_rdata;
    req_t i_req = '0;
    resp_t o_resp;
    bus_t o_bus;
    attr_t i_attr;
    halt_mode_t i_halt_mode = HALT_SLEEP, o_halt_mode;
    cpu_state_t o_cpu_state;
    logic [7:0] rm [65536] = '{default: 8'h00};
    logic [31:0] wq [$];
    logic pw = 0;
    logic [15:0] pa = 0;
    int fails = 0, num_checks = 0, lat;
    cpu_bus_cycle_rmw dut (.i_clk, .i_reset_n, .i_clk_en, .i_main_tick, .i_sub_tick, .i_req_valid,
        .i_req, .o_busy, .o_resp, .o_bus, .i_attr, .i_rdata, .i_port5_pins,
        .i_port5_direction_control, .i_port5_output_latch, .i_exc_req, .i_exc_done,
        .i_halt_req, .i_halt_mode, .i_wake, .i_sub_sel, .o_cpu_state, .o_sub_active, .o_halt_mode);
    periph_model u_mem (.i_clk, .i_bus(o_bus), .o_attr(i_attr), .o_rdata(i_rdata));
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) i_sub_tick <= #1 1'($urandom);
    // sampled on the falling edge so registered strobes have settled
    always @(negedge i_clk) begin
        if (o_bus.wr && (!pw || o_bus.addr != pa)) wq.push_back({o_bus.addr, o_bus.wdata});
        pw <= o_bus.wr;
        pa <= o_bus.addr;
    end
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    function automatic logic [31:0] wg(int i);
        return wq.size() > i ? wq[i] : 32'hxxxx_xxxx;
    endfunction
    function automatic logic [7:0] rb(logic [15:0] a);
        if (a[15:8] == 8'hF3) return 8'hFF;
        if (a[15:8] == 8'hF4) return (i_port5_pins & ~i_port5_direction_control) |
            (i_port5_output_latch & i_port5_direction_control);
        return rm[a];
    endfunction
    task automatic op(op_t o, logic w, logic [15:0] a, logic [15:0] d, logic [7:0] b);
        logic [15:0] e;
        logic [7:0] v;
        logic [31:0] w0;
        logic ee;
        int n;
        e = w ? {rb({a[15:1], 1'b0}), rb({a[15:1], 1'b1})} : {8'h00, rb(a)};
        v = rb(a);
        ee = a[15:8] == 8'hF2 && !w;
        case (o)
            OP_SET_BIT: v[b[2:0]] = 1'b1;
            OP_CLEAR_BIT: v[b[2:0]] = 1'b0;
            OP_INVERT_BIT: v[b[2:0]] = ~v[b[2:0]];
            OP_STORE_BIT: v[b[2:0]] = d[0];
            OP_STORE_INV_BIT: v[b[2:0]] = ~d[0];
            default: ;
        endcase
        wq.delete();
        cyc(1);
        i_req = '{o, w, {8'($urandom), a}, d, b[2:0], d[0], b, a, d};
        i_req_valid = 1;
        n = 0;
        do begin
            cyc(1);
            n++;
            if (o_busy === 1'b1 || o_resp.done === 1'b1) i_req_valid = 0;
        end while (o_resp.done !== 1'b1 && n < 400);
        if (n >= 400) begin
            fails++;
            finish_test();
        end
        lat = n;
        chk("err", 16'(o_resp.err), 16'(ee));
        if (ee) chk("no strobe", 16'(wq.size()), 16'h0);
        if (o == OP_READ && !ee && a[15:12] != 4'hE) chk("rdata", o_resp.rdata, e);
        if (o > OP_WRITE && o < OP_BLOCK_COPY && !ee) begin
            w0 = wg(0);
            chk("rmw addr", w0[31:16], a);
            chk("rmw byte", {8'h00, w0[7:0]}, {8'h00, v});
            rm[a] = v;
        end
        if (o == OP_WRITE && a[15:12] != 4'hE && w) {rm[{a[15:1], 1'b0}], rm[a | 16'h1]} = d;
        if (o == OP_WRITE && a[15:12] != 4'hE && !w) rm[a] = d[7:0];
    endtask
    initial begin
        logic [15:0] d;
        logic [31:0] w0;
        int l2, ls;
        void'($urandom(76));
        cyc(4);
        i_reset_n = 1;
        cyc(3);
        chk("state", 16'(o_cpu_state), 16'(CPU_EXCEPT));
        i_exc_done = 1;
        cyc(2);
        i_exc_done = 0;
        chk("state", 16'(o_cpu_state), 16'(CPU_EXEC));
        d = 16'($urandom);
        op(OP_WRITE, 1, 16'h0010, d, 0);
        op(OP_READ, 1, 16'h0010, 0, 0);
        l2 = lat;
        op(OP_READ, 0, 16'h0011, 0, 0);
        op(OP_WRITE, 1, 16'hF010, d, 0);
        chk("split n", 16'(wq.size()), 16'h2);
        chk("even first", 16'(wg(0) >> 16), 16'hF010);
        chk("odd next", 16'(wg(1) >> 16), 16'hF011);
        op(OP_READ, 1, 16'hF010, 0, 0);
        ls = lat;
        op(OP_READ, 0, 16'hF011, 0, 0);
        chk("3 state", 16'(lat), 16'(l2 + 1));
        chk("split lat", 16'(ls), 16'(lat + 3));
        op(OP_WRITE, 0, 16'hF121, {2{d[7:0]}}, 0);
        op(OP_READ, 0, 16'hF121, 0, 0);
        chk("2 state", 16'(lat), 16'(l2));
        op(OP_WRITE, 1, 16'hF200, ~d, 0);
        op(OP_READ, 1, 16'hF200, 0, 0);
        op(OP_READ, 0, 16'hF201, 0, 0);
        op(OP_SET_BIT, 0, 16'hF200, 0, 1);
        for (int k = 0; k < 5; k++) begin
            op(OP_WRITE, 0, 16'h0021, {2{8'($urandom)}}, 0);
            op(op_t'(k + 2), 0, 16'h0021, 16'($urandom), 8'(k + 2));
        end
        op(OP_INVERT_BIT, 0, 16'hF031, 0, 7);
        op(OP_CLEAR_BIT, 0, 16'hF300, 0, 0);
        {i_port5_pins, i_port5_direction_control, i_port5_output_latch} = 24'($urandom);
        cyc(8);
        op(OP_SET_BIT, 0, 16'hF400, 0, 0);
        op(OP_WRITE, 0, 16'hE004, 16'hFFFF, 0);
        chk("empty wr", 16'(wq.size()), 16'h0);
        op(OP_WRITE, 1, 16'h0100, 16'($urandom), 0);
        op(OP_WRITE, 1, 16'h0102, 16'($urandom), 0);
        op(OP_BLOCK_COPY, 0, 16'h0101, 16'h0200, 3);
        for (int k = 0; k < 3; k++) begin
            w0 = wg(k);
            chk("copy addr", w0[31:16], 16'(16'h0200 + k));
            chk("copy byte", {8'h00, w0[7:0]}, {8'h00, rm[16'h0101 + k]});
            rm[16'h0200 + k] = rm[16'h0101 + k];
        end
        op(OP_BLOCK_COPY, 0, 16'h0101, 16'h0300, 0);
        chk("copy none", 16'(wq.size()), 16'h0);
        $display("test bus done");
        i_sub_sel = 1;
        cyc(8);
        chk("sub", 16'(o_sub_active), 16'h1);
        i_main_tick = 0;
        op(OP_READ, 1, 16'h0200, 0, 0);
        i_main_tick = 1;
        i_sub_sel = 0;
        cyc(8);
        chk("active", 16'(o_sub_active), 16'h0);
        for (int k = 0; k < 3; k++) begin
            i_halt_mode = halt_mode_t'(k == 2 ? 3 : k);
            i_halt_req = 1;
            cyc(3);
            i_halt_req = 0;
            chk("halt", 16'(o_cpu_state), 16'(CPU_HALT));
            chk("mode", 16'(o_halt_mode), 16'(i_halt_mode));
            i_wake = 1;
            cyc(3);
            i_wake = 0;
            chk("wake", 16'(o_cpu_state), 16'(CPU_EXEC));
        end
        i_exc_req = 1;
        cyc(3);
        i_exc_req = 0;
        chk("exc", 16'(o_cpu_state), 16'(CPU_EXCEPT));
        $display("test state done");
        finish_test();
    end
endmodule
